// ===== include/mmd_pkg.sv
package mmd_pkg;

  // ==========================================================
  // Direct register map and fields
  localparam logic [4:0]  CTRL_REG_ADDR   = 5'h0d;
  localparam logic [4:0]  PORT_REG_ADDR   = 5'h0e;
  localparam int          FN_MSB          = 15;
  localparam int          FN_LSB          = 14;
  localparam int          DEVSEL_MSB      = 4;
  localparam logic [4:0]  DEVSEL_GENERAL  = 5'h1f;
  localparam logic [1:0]  FN_ADDRESS      = 2'h0;
  localparam logic [1:0]  FN_DATA         = 2'h1;
  localparam logic [1:0]  FN_DATA_INC_RW  = 2'h2;
  localparam logic [1:0]  FN_DATA_INC_WR  = 2'h3;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  localparam logic [15:0] EXT_ADDR_RESET  = 16'h0000;

  // ==========================================================
  // Extended registers
  localparam logic [15:0] CLK_CFG_ADDR    = 16'h0170;
  localparam logic [15:0] CLK_CFG_RESET   = 16'h0c10;
  localparam int          CLK_OFF_BIT     = 6;

  // ==========================================================
  // Serial frame layout
  localparam logic [1:0]  OP_READ         = 2'h2;
  localparam logic [1:0]  OP_WRITE        = 2'h1;
  localparam logic [3:0]  OP_LAST         = 4'h1;
  localparam logic [3:0]  ADDR_LAST       = 4'h4;
  localparam logic [3:0]  TURN_LAST       = 4'h1;
  localparam logic [3:0]  DATA_LAST       = 4'hf;
  localparam logic [4:0]  PHY_ADDR_DEF    = 5'h01;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_OP    = 3'h3,
    ST_PHYAD = 3'h2,
    ST_REGAD = 3'h6,
    ST_TURN  = 3'h7,
    ST_DATA  = 3'h5
  } frame_state_t;

  typedef struct packed {
    logic rise;
    logic data;
  } link_sample_t;

  typedef struct packed {
    logic [2:0] mdc_pipe;
    logic [1:0] mdio_pipe;
    link_sample_t smp;
  } sync_state_t;

  typedef struct packed {
    frame_state_t fsm;
    logic [3:0]   cnt;
    logic [1:0]   op;
    logic [4:0]   phyad;
    logic [4:0]   regad;
    logic [15:0]  shift;
    logic         hit;
    logic [15:0]  ctrl;
    logic [15:0]  ext_addr;
    logic [15:0]  clk_cfg;
    logic         cfg_written;
    logic         mdio_o;
    logic         mdio_oe;
    logic         clk_out_en;
  } core_state_t;

endpackage

// ===== core/mdc_sampler.sv
`timescale 1ns/1ps
module mdc_sampler (
  input  wire logic           clk_in,
  input  wire logic           resetn_in,
  input  wire logic           mdc_in,
  input  wire logic           mdio_in,
  output mmd_pkg::link_sample_t smp_out
);
  import mmd_pkg::*;

  sync_state_t st_reg;
  sync_state_t st_next;

  // ==========================================================
  // Two-stage capture and rising edge find
  always_comb begin
    st_next           = st_reg;
    st_next.mdc_pipe  = {st_reg.mdc_pipe[1:0], mdc_in};
    st_next.mdio_pipe = {st_reg.mdio_pipe[0], mdio_in};
    st_next.smp.rise  = st_reg.mdc_pipe[1] & ~st_reg.mdc_pipe[2];
    st_next.smp.data  = st_reg.mdio_pipe[1];
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign smp_out = st_reg.smp;

endmodule

// ===== core/mmd_indirect_access.sv
`timescale 1ns/1ps
module mmd_indirect_access #(
  parameter logic [4:0] PHY_ADDR = mmd_pkg::PHY_ADDR_DEF
) (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic mdc_in,
  input  wire logic mdio_in,
  output wire logic mdio_out,
  output wire logic mdio_oe_out,
  output wire logic clk_out_en_out
);
  import mmd_pkg::*;

  core_state_t  st_reg;
  core_state_t  st_next;
  link_sample_t smp;
  logic         wr_commit;
  logic         rd_done;
  logic         dev_ok;
  logic [1:0]   fn;
  logic [15:0]  wdata;
  logic [4:0]   regad_now;

  mdc_sampler u_sampler (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .mdc_in    (mdc_in),
    .mdio_in   (mdio_in),
    .smp_out   (smp)
  );

  // ==========================================================
  // Read value selection
  function automatic logic [15:0] ext_read(input core_state_t s);
    // Only real extended registers answer; 0x0D/0x0E are not among them
    if (s.ext_addr == CLK_CFG_ADDR) begin
      return s.clk_cfg;
    end
    return 16'h0000;
  endfunction

  function automatic logic [15:0] direct_read(input core_state_t s,
                                              input logic [4:0]  ra);
    logic [15:0] v;
    v = 16'h0000;
    if (ra == CTRL_REG_ADDR) begin
      v = s.ctrl;
    end else if (ra == PORT_REG_ADDR &&
                 s.ctrl[DEVSEL_MSB:0] == DEVSEL_GENERAL) begin
      if (s.ctrl[FN_MSB:FN_LSB] == FN_ADDRESS) begin
        v = s.ext_addr;
      end else begin
        v = ext_read(s);
      end
    end
    return v;
  endfunction

  // ==========================================================
  // Frame engine and register effects
  always_comb begin
    st_next   = st_reg;
    wr_commit = 1'b0;
    rd_done   = 1'b0;
    fn        = st_reg.ctrl[FN_MSB:FN_LSB];
    dev_ok    = st_reg.ctrl[DEVSEL_MSB:0] == DEVSEL_GENERAL;
    wdata     = {st_reg.shift[14:0], smp.data};
    regad_now = {st_reg.regad[3:0], smp.data};
    if (smp.rise) begin
      unique case (st_reg.fsm)
        ST_IDLE: begin
          st_next.cnt = 4'h0;
          if (!smp.data) begin
            st_next.fsm = ST_START;
          end
        end
        ST_START: begin
          st_next.fsm = smp.data ? ST_OP : ST_IDLE;
        end
        ST_OP: begin
          st_next.op  = {st_reg.op[0], smp.data};
          st_next.cnt = 4'(st_reg.cnt + 4'h1);
          if (st_reg.cnt == OP_LAST) begin
            st_next.fsm = ST_PHYAD;
            st_next.cnt = 4'h0;
          end
        end
        ST_PHYAD: begin
          st_next.phyad = {st_reg.phyad[3:0], smp.data};
          st_next.cnt   = 4'(st_reg.cnt + 4'h1);
          if (st_reg.cnt == ADDR_LAST) begin
            st_next.fsm = ST_REGAD;
            st_next.cnt = 4'h0;
          end
        end
        ST_REGAD: begin
          st_next.regad = regad_now;
          st_next.cnt   = 4'(st_reg.cnt + 4'h1);
          if (st_reg.cnt == ADDR_LAST) begin
            st_next.fsm   = ST_TURN;
            st_next.cnt   = 4'h0;
            st_next.hit   = st_reg.phyad == PHY_ADDR;
            st_next.shift = direct_read(st_reg, regad_now);
          end
        end
        ST_TURN: begin
          st_next.cnt = 4'(st_reg.cnt + 4'h1);
          if (st_reg.op == OP_READ && st_reg.hit) begin
            st_next.mdio_oe = 1'b1;
            st_next.mdio_o  = 1'b0;
          end
          if (st_reg.cnt == TURN_LAST) begin
            st_next.fsm = ST_DATA;
            st_next.cnt = 4'h0;
            if (st_reg.op == OP_READ) begin
              st_next.mdio_o = st_reg.shift[15];
              st_next.shift  = {st_reg.shift[14:0], 1'b0};
            end
          end
        end
        ST_DATA: begin
          st_next.cnt = 4'(st_reg.cnt + 4'h1);
          if (st_reg.op == OP_READ) begin
            st_next.mdio_o = st_reg.shift[15];
            st_next.shift  = {st_reg.shift[14:0], 1'b0};
          end else begin
            st_next.shift = wdata;
          end
          if (st_reg.cnt == DATA_LAST) begin
            st_next.fsm     = ST_IDLE;
            st_next.cnt     = 4'h0;
            st_next.mdio_oe = 1'b0;
            st_next.mdio_o  = 1'b0;
            wr_commit = st_reg.hit && st_reg.op == OP_WRITE;
            rd_done   = st_reg.hit && st_reg.op == OP_READ;
          end
        end
        default: begin
          st_next.fsm     = ST_IDLE;
          st_next.mdio_oe = 1'b0;
        end
      endcase
    end

    // Post-increment lands after the frame, data used old address
    if (rd_done && st_reg.regad == PORT_REG_ADDR && dev_ok &&
        fn == FN_DATA_INC_RW) begin
      st_next.ext_addr = 16'(st_reg.ext_addr + 16'h0001);
    end
    if (wr_commit && st_reg.regad == CTRL_REG_ADDR) begin
      st_next.ctrl = wdata;
    end
    if (wr_commit && st_reg.regad == PORT_REG_ADDR && dev_ok) begin
      if (fn == FN_ADDRESS) begin
        st_next.ext_addr = wdata;
      end else begin
        if (st_reg.ext_addr == CLK_CFG_ADDR) begin
          st_next.clk_cfg     = wdata;
          st_next.cfg_written = 1'b1;
        end
        if (fn[1]) begin
          st_next.ext_addr = 16'(st_reg.ext_addr + 16'h0001);
        end
      end
    end
    st_next.clk_out_en = ~st_next.clk_cfg[CLK_OFF_BIT];
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_reg             <= '0;
      st_reg.ctrl        <= CTRL_RESET;
      st_reg.ext_addr    <= EXT_ADDR_RESET;
      st_reg.clk_cfg     <= CLK_CFG_RESET;
      st_reg.clk_out_en  <= ~CLK_CFG_RESET[CLK_OFF_BIT];
    end else begin
      st_reg <= st_next;
    end
  end

  assign mdio_out       = st_reg.mdio_o;
  assign mdio_oe_out    = st_reg.mdio_oe;
  assign clk_out_en_out = st_reg.clk_out_en;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  a_ctrl_direct_write: assert property (
    wr_commit && st_reg.regad == CTRL_REG_ADDR |=> st_reg.ctrl == $past(wdata))
    else $error("control write not stored");
  a_addr_mode_load: assert property (
    wr_commit && st_reg.regad == PORT_REG_ADDR && dev_ok && fn == FN_ADDRESS
    |=> st_reg.ext_addr == $past(wdata))
    else $error("address load missed");
  a_addr_mode_read: assert property (
    smp.rise && st_reg.fsm == ST_REGAD && st_reg.cnt == ADDR_LAST &&
    regad_now == PORT_REG_ADDR && dev_ok && fn == FN_ADDRESS
    |=> st_reg.shift == st_reg.ext_addr)
    else $error("address read wrong");
  a_data_no_inc: assert property (
    (wr_commit || rd_done) && fn == FN_DATA |=> $stable(st_reg.ext_addr))
    else $error("address moved in function 01");
  a_write_inc: assert property (
    wr_commit && st_reg.regad == PORT_REG_ADDR && dev_ok && fn[1]
    |=> st_reg.ext_addr == 16'($past(st_reg.ext_addr) + 16'h0001))
    else $error("write increment wrong");
  a_read_inc: assert property (
    rd_done && st_reg.regad == PORT_REG_ADDR && dev_ok && fn == FN_DATA_INC_RW
    |=> st_reg.ext_addr == 16'($past(st_reg.ext_addr) + 16'h0001))
    else $error("read increment wrong");
  a_fn11_read_hold: assert property (
    rd_done && fn == FN_DATA_INC_WR |=> $stable(st_reg.ext_addr))
    else $error("function 11 read moved address");
  a_devsel_ignore: assert property (
    wr_commit && st_reg.regad == PORT_REG_ADDR && !dev_ok
    |=> $stable(st_reg.ext_addr) && $stable(st_reg.clk_cfg))
    else $error("foreign device select acted");
  a_cfg_reset_val: assert property (
    !st_reg.cfg_written |-> st_reg.clk_cfg == CLK_CFG_RESET)
    else $error("clock config reset value lost");
  a_clkout_follow: assert property (
    clk_out_en_out == ~st_reg.clk_cfg[CLK_OFF_BIT])
    else $error("clock output enable mismatch");

  c_addr_load: cover property (
    wr_commit && st_reg.regad == PORT_REG_ADDR && fn == FN_ADDRESS);
  c_data_write: cover property (
    wr_commit && st_reg.regad == PORT_REG_ADDR && fn == FN_DATA);
  c_inc_read: cover property (rd_done && fn == FN_DATA_INC_RW);
  c_clk_off: cover property ($fell(clk_out_en_out));

endmodule

// ===== tb/mdio_station.sv
`timescale 1ns/1ps
module mdio_station (
  input  wire logic clk_in,
  input  wire logic mdio_in,
  output logic      mdc_out,
  output logic      mdio_out,
  output logic      mdio_oe_out
);
  // ==========================================================
  // Idle bus: clock still, line released
  initial begin
    mdc_out     = 1'b0;
    mdio_out    = 1'b1;
    mdio_oe_out = 1'b0;
  end

  // ==========================================================
  // One frame, eight clocks a bit, sampled on each rise
  task automatic frame(input  logic [1:0]  op,
                       input  logic [4:0]  phy,
                       input  logic [4:0]  ra,
                       input  logic [15:0] wd,
                       output logic [15:0] rd);
    logic [31:0] bits;
    bits = {2'b01, op, phy, ra, 2'b10, wd};
    rd   = 16'h0000;
    for (int i = 0; i < 32; i++) begin
      @(negedge clk_in);
      mdio_oe_out = !(op == 2'b10 && i >= 14);
      mdio_out    = bits[31-i];
      repeat (3) @(negedge clk_in);
      if (i >= 16) begin
        rd[31-i] = mdio_in;
      end
      mdc_out = 1'b1;
      repeat (4) @(negedge clk_in);
      mdc_out = 1'b0;
    end
    mdio_oe_out = 1'b0;
  endtask
endmodule

// ===== tb/mmd_indirect_register_access_test.sv
`timescale 1ns/1ps
module mmd_indirect_register_access_test;
  import mmd_pkg::*;
  logic        clk_in;
  logic        resetn_in;
  logic        mdc;
  logic        sta_mdio;
  logic        sta_oe;
  logic        dut_mdio;
  logic        dut_oe;
  logic        clk_en;
  logic        mdio_wire;
  logic [15:0] rdata;
  logic [15:0] v;
  logic [15:0] a;
  int          fails;
  int          n_checks;

  // ==========================================================
  // Wire with pull-up
  assign mdio_wire = dut_oe ? dut_mdio : (sta_oe ? sta_mdio : 1'b1);

  mmd_indirect_access #(.PHY_ADDR(PHY_ADDR_DEF)) i_dut (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .mdc_in        (mdc),
    .mdio_in       (mdio_wire),
    .mdio_out      (dut_mdio),
    .mdio_oe_out   (dut_oe),
    .clk_out_en_out(clk_en)
  );

  mdio_station i_sta (
    .clk_in     (clk_in),
    .mdio_in    (mdio_wire),
    .mdc_out    (mdc),
    .mdio_out   (sta_mdio),
    .mdio_oe_out(sta_oe)
  );

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // ==========================================================
  // Helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    i_sta.frame(OP_WRITE, PHY_ADDR_DEF, ra, d, rdata);
    repeat (8) @(negedge clk_in);
  endtask

  task automatic rd(input logic [4:0] ra);
    i_sta.frame(OP_READ, PHY_ADDR_DEF, ra, 16'h0000, rdata);
  endtask

  function automatic logic [15:0] ctl(input logic [1:0] fn);
    return {fn, 9'h000, DEVSEL_GENERAL};
  endfunction

  function automatic logic [15:0] next_addr(input logic [1:0] fn);
    return CLK_CFG_ADDR + ((fn == FN_DATA_INC_RW) ? 16'h0002 : 16'h0001);
  endfunction

  task automatic seta(input logic [15:0] ad);
    wr(CTRL_REG_ADDR, ctl(FN_ADDRESS));
    wr(PORT_REG_ADDR, ad);
  endtask

  task automatic ext_read(input logic [15:0] ad);
    seta(ad);
    wr(CTRL_REG_ADDR, ctl(FN_DATA));
    rd(PORT_REG_ADDR);
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk_in);
    fails++;
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    fails     = 0;
    n_checks  = 0;
    resetn_in = 1'b0;
    void'($urandom(56140));
    repeat (20) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (20) @(negedge clk_in);
    check({15'h0, clk_en}, 16'h0001);
    ext_read(CLK_CFG_ADDR);
    check(rdata, CLK_CFG_RESET);
    rd(CTRL_REG_ADDR);
    check(rdata, ctl(FN_DATA));
    repeat (3) begin
      a = 16'($urandom);
      seta(a);
      rd(PORT_REG_ADDR);
      check(rdata, a);
    end
    wr(PORT_REG_ADDR, CLK_CFG_ADDR);
    wr(CTRL_REG_ADDR, ctl(FN_DATA));
    wr(PORT_REG_ADDR, 16'h0c50);
    check({15'h0, clk_en}, 16'h0000);
    v = 16'($urandom);
    wr(PORT_REG_ADDR, v);
    check({15'h0, clk_en}, {15'h0, ~v[CLK_OFF_BIT]});
    repeat (2) begin
      rd(PORT_REG_ADDR);
      check(rdata, v);
    end
    wr(CTRL_REG_ADDR, ctl(FN_ADDRESS));
    rd(PORT_REG_ADDR);
    check(rdata, CLK_CFG_ADDR);
    wr(CTRL_REG_ADDR, ctl(FN_DATA_INC_RW));
    rd(PORT_REG_ADDR);
    check(rdata, v);
    rd(PORT_REG_ADDR);
    check(rdata, 16'h0000);
    for (int f = 2; f < 4; f++) begin
      seta(CLK_CFG_ADDR - 16'h0001);
      wr(CTRL_REG_ADDR, ctl(2'(f)));
      v = 16'($urandom);
      wr(PORT_REG_ADDR, ~v);
      wr(PORT_REG_ADDR, v);
      rd(PORT_REG_ADDR);
      check(rdata, 16'h0000);
      wr(CTRL_REG_ADDR, ctl(FN_ADDRESS));
      rd(PORT_REG_ADDR);
      check(rdata, next_addr(2'(f)));
      ext_read(CLK_CFG_ADDR);
      check(rdata, v);
    end
    wr(CTRL_REG_ADDR, {FN_DATA, 14'h0000});
    wr(PORT_REG_ADDR, ~v);
    rd(PORT_REG_ADDR);
    check(rdata, 16'h0000);
    ext_read(CLK_CFG_ADDR);
    check(rdata, v);
    // Opcode other than read or write changes nothing
    i_sta.frame(2'h0, PHY_ADDR_DEF, PORT_REG_ADDR, ~v, rdata);
    rd(PORT_REG_ADDR);
    check(rdata, v);
    seta(16'h000d);
    wr(CTRL_REG_ADDR, ctl(FN_DATA));
    wr(PORT_REG_ADDR, 16'h0000);
    rd(PORT_REG_ADDR);
    check(rdata, 16'h0000);
    rd(CTRL_REG_ADDR);
    check(rdata, ctl(FN_DATA));
    i_sta.frame(OP_READ, PHY_ADDR_DEF + 5'h01, CTRL_REG_ADDR, 16'h0000, rdata);
    check(rdata, 16'hffff);
    // Reset in mid-run restores every register
    @(negedge clk_in);
    resetn_in = 1'b0;
    repeat (20) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (20) @(negedge clk_in);
    check({15'h0, clk_en}, 16'h0001);
    rd(CTRL_REG_ADDR);
    check(rdata, CTRL_RESET);
    ext_read(CLK_CFG_ADDR);
    check(rdata, CLK_CFG_RESET);
    finish_test();
  end
endmodule
